// ---- include/potx_pkg.sv ----
// path overhead transmit inserter: shared constants, enums and carriers
// assumes one byte per clock on the transmit stream with slot tags from the frame counter
package potx_pkg;

	localparam logic [7:0] OH_DEFAULT = 8'h00;
	localparam logic [7:0] AIS_BYTE = 8'hff;
	localparam logic [3:0] NDF_NORMAL = 4'h6;
	localparam logic [3:0] NDF_SET = 4'h9;
	localparam logic [1:0] CONC_H1_LOW = 2'h3;
	localparam logic [7:0] CONC_H2 = 8'hff;
	localparam logic [9:0] PTR_MAX = 10'h30e;
	localparam logic [9:0] PTR_I_MASK = 10'h2aa;
	localparam logic [9:0] PTR_D_MASK = 10'h155;
	localparam logic [2:0] PTR_MOVE_GAP = 3'h4;

	localparam logic [2:0] RDI_NONE_STD = 3'h0;
	localparam logic [2:0] RDI_DEF_STD = 3'h4;
	localparam logic [2:0] RDI_NONE_ALT = 3'h3;
	localparam logic [2:0] RDI_DEF_ALT = 3'h7;
	localparam logic [2:0] RDI_NONE_ENH = 3'h1;
	localparam logic [2:0] RDI_SERVER = 3'h5;
	localparam logic [2:0] RDI_CONN = 3'h6;
	localparam logic [2:0] RDI_PAYLOAD = 3'h2;

	localparam logic [4:0] HOLD_N0 = 5'h14;
	localparam logic [4:0] HOLD_N1 = 5'h0a;
	localparam logic [4:0] HOLD_N2 = 5'h05;
	localparam logic [4:0] HOLD_N3 = 5'h01;
	localparam logic [4:0] STAB_MAX = 5'h1f;

	typedef enum logic [3:0] {
		SL_PAYLOAD, SL_C2, SL_G1, SL_H4, SL_F2, SL_F3, SL_Z4, SL_Z5,
		SL_H1_PTR, SL_H2_PTR, SL_H1_CONC, SL_H2_CONC, SL_H3, SL_PJO,
		SL_STUFF, SL_OTHER_POH
	} potx_slot_type;

	typedef enum logic [2:0] {
		SRC_DEFAULT, SRC_SERIAL, SRC_ALARM, SRC_PASS, SRC_REG, SRC_INTERNAL, SRC_OW
	} potx_src_type;

	typedef enum logic [1:0] {MV_NONE, MV_INC, MV_DEC, MV_NDF} potx_move_type;

	typedef struct packed {
		logic unequipped;
		potx_src_type c2_src;
		potx_src_type rei_src;
		potx_src_type rdi_src;
		potx_src_type h4_src;
		potx_src_type f2_src;
		potx_src_type f3_src;
		potx_src_type z4_src;
		potx_src_type z5_src;
		logic rei_en;
		logic rdi_enh;
		logic rdi_alt;
		logic [1:0] rdi_hold_sel;
		logic uneq_en;
		logic tim_en;
		logic slm_en;
		logic slm_payload;
		logic lcd_en;
		logic sts1_mode;
		logic stuff_cols;
		logic conc_inv;
		logic force_ais;
	} potx_cfg_type;

	typedef struct packed {
		logic aisp;
		logic lop;
		logic uneq;
		logic tim;
		logic slm;
		logic lcd;
		logic [3:0] b3_err;
	} potx_defect_type;

	typedef struct packed {
		logic [7:0] data;
		logic bip_excl;
		logic just_pos;
		logic just_neg;
	} potx_out_type;

endpackage

// ---- logic/potx_ser_rx.sv ----
// serial overhead input: assembles msb-first bits into bytes
// assumes bit strobe and byte sync pins from the overhead port, asynchronous to clk_i
`timescale 1ns/100ps
`default_nettype none
module potx_ser_rx (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// serial pins
	input wire logic bit_i,
	input wire logic strobe_i,
	input wire logic sync_i,
	// assembled byte
	output logic [7:0] byte_o
);
	logic [2:0] s1_ff;
	logic [2:0] s2_ff;
	logic strobe_d_ff;
	logic [6:0] shift_ff;
	logic edge_w;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_ff <= 3'h0;
			s2_ff <= 3'h0;
			strobe_d_ff <= 1'b0;
		end else begin
			s1_ff <= {sync_i, strobe_i, bit_i};
			s2_ff <= s1_ff;
			strobe_d_ff <= s2_ff[1];
		end
	end

	assign edge_w = s2_ff[1] & ~strobe_d_ff;

	// byte sync marks the last bit of a byte
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shift_ff <= 7'h00;
			byte_o <= 8'h00;
		end else if (edge_w) begin
			shift_ff <= {shift_ff[5:0], s2_ff[0]};
			if (s2_ff[2]) begin
				byte_o <= {shift_ff, s2_ff[0]};
			end
		end
	end
endmodule
`default_nettype wire

// ---- logic/potx_rdi_gen.sv ----
// remote defect code builder from receiver defects, with frame hold
// assumes defect levels on clk_i and a one-cycle frame start pulse
`timescale 1ns/100ps
`default_nettype none
module potx_rdi_gen (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// frame and defects
	input wire logic frame_start_i,
	input wire potx_pkg::potx_defect_type dfct_i,
	input wire potx_pkg::potx_cfg_type cfg_i,
	// code
	output logic [2:0] code_o
);
	logic server_w;
	logic conn_w;
	logic pay_w;
	logic [2:0] raw_w;
	logic [4:0] hold_n_w;
	logic [4:0] hold_ff;
	logic [4:0] stab_ff;
	logic [4:0] hold_len_ff;

	assign server_w = dfct_i.aisp | dfct_i.lop;
	assign conn_w = (dfct_i.uneq & cfg_i.uneq_en) | (dfct_i.tim & cfg_i.tim_en)
		| (dfct_i.slm & cfg_i.slm_en & ~cfg_i.slm_payload);
	assign pay_w = (dfct_i.slm & cfg_i.slm_en & cfg_i.slm_payload)
		| (dfct_i.lcd & cfg_i.lcd_en);

	always_comb begin
		if (cfg_i.rdi_enh) begin
			if (server_w) begin
				raw_w = potx_pkg::RDI_SERVER;
			end else if (conn_w) begin
				raw_w = potx_pkg::RDI_CONN;
			end else if (pay_w) begin
				raw_w = potx_pkg::RDI_PAYLOAD;
			end else begin
				raw_w = potx_pkg::RDI_NONE_ENH;
			end
		end else if (server_w | conn_w | pay_w) begin
			raw_w = cfg_i.rdi_alt ? potx_pkg::RDI_DEF_ALT : potx_pkg::RDI_DEF_STD;
		end else begin
			raw_w = cfg_i.rdi_alt ? potx_pkg::RDI_NONE_ALT : potx_pkg::RDI_NONE_STD;
		end
	end

	always_comb begin
		unique case (cfg_i.rdi_hold_sel)
			2'h0: hold_n_w = potx_pkg::HOLD_N0;
			2'h1: hold_n_w = potx_pkg::HOLD_N1;
			2'h2: hold_n_w = potx_pkg::HOLD_N2;
			2'h3: hold_n_w = potx_pkg::HOLD_N3;
		endcase
	end

	// a new code is held for n frames before it may change again
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			code_o <= potx_pkg::RDI_NONE_STD;
			hold_ff <= 5'h00;
		end else if (frame_start_i) begin
			if (hold_ff != 5'h00) begin
				hold_ff <= hold_ff - 5'h01;
			end else if (raw_w != code_o) begin
				code_o <= raw_w;
				hold_ff <= hold_n_w - 5'h01;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stab_ff <= potx_pkg::STAB_MAX;
			hold_len_ff <= potx_pkg::HOLD_N3;
		end else if (frame_start_i && hold_ff == 5'h00 && raw_w != code_o) begin
			stab_ff <= 5'h00;
			// the hold that applies is the one chosen when the code was adopted
			hold_len_ff <= hold_n_w;
		end else if (frame_start_i && stab_ff != potx_pkg::STAB_MAX) begin
			stab_ff <= stab_ff + 5'h01;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	AST_RDI_HOLD: assert property (code_o != $past(code_o)
		|-> {1'b0, $past(stab_ff)} + 6'h01 >= {1'b0, $past(hold_len_ff)})
		else $error("rdi code changed before hold expired");
	AST_RDI_PRIO: assert property (frame_start_i && hold_ff == 5'h00 && cfg_i.rdi_enh
		&& server_w |=> code_o == potx_pkg::RDI_SERVER)
		else $error("server defect not coded first");
	AST_RDI_STD: assert property (frame_start_i && hold_ff == 5'h00 && !cfg_i.rdi_enh
		&& !cfg_i.rdi_alt && (server_w | conn_w | pay_w) |=> code_o == potx_pkg::RDI_DEF_STD)
		else $error("standard rdi defect code wrong");
	COV_RDI_SERVER: cover property (code_o == potx_pkg::RDI_SERVER);
endmodule
`default_nettype wire

// ---- logic/potx_inserter.sv ----
// transmit path overhead inserter and au pointer generator for one channel
// assumes slot tags aligned with dn_data_i each cycle and a frame start pulse per frame
`timescale 1ns/100ps
`default_nettype none
module potx_inserter (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// transmit stream in
	input wire logic frame_start_i,
	input wire potx_pkg::potx_slot_type slot_i,
	input wire logic [7:0] dn_data_i,
	// serial overhead pins
	input wire logic path_oh_serial_in_i,
	input wire logic path_alarm_serial_in_i,
	input wire logic oh_bit_strobe_i,
	input wire logic oh_byte_sync_i,
	input wire logic path_oh_insert_select_i,
	// orderwire pins
	input wire logic path_orderwire1_in_i,
	input wire logic path_orderwire2_in_i,
	input wire logic ow_bit_strobe_i,
	input wire logic ow_byte_sync_i,
	// configuration
	input wire potx_pkg::potx_cfg_type tx_path_source_cfg_i,
	input wire logic [7:0] tx_signal_label_reg_i,
	input wire logic [3:0] tx_path_defect_reg_i,
	input wire logic [1:0] tx_pointer_size_i,
	input wire logic [9:0] tx_pointer_setting_i,
	// pointer test commands
	input wire logic ptr_inc_i,
	input wire logic ptr_dec_i,
	input wire logic ptr_new_data_flag_i,
	// receiver defects
	input wire potx_pkg::potx_defect_type dfct_i,
	// outputs
	output potx_pkg::potx_out_type tx_o,
	output logic [9:0] tx_current_pointer_o,
	output logic [2:0] rdi_code_o
);
	localparam int NSER = 4;

	logic [NSER-1:0] ser_pin_w;
	logic [NSER-1:0] ser_strobe_w;
	logic [NSER-1:0] ser_sync_w;
	logic [7:0] ser_byte_w [NSER];
	logic ins1_ff;
	logic ins_ff;
	logic [2:0] pend_ff;
	logic [2:0] gap_ff;
	potx_pkg::potx_move_type move_ff;
	logic [9:0] cur_ff;
	logic [9:0] prog_ff;
	logic [9:0] ptr_tx_w;
	logic [3:0] rei_int_w;
	logic [7:0] rei_byte_w;
	logic [7:0] rdi_byte_w;
	logic [7:0] rdi_int_w;
	potx_pkg::potx_out_type nxt_out;
	potx_pkg::potx_cfg_type cfg;

	assign cfg = tx_path_source_cfg_i;
	assign ser_pin_w = {path_orderwire2_in_i, path_orderwire1_in_i,
		path_alarm_serial_in_i, path_oh_serial_in_i};
	assign ser_strobe_w = {ow_bit_strobe_i, ow_bit_strobe_i, oh_bit_strobe_i, oh_bit_strobe_i};
	assign ser_sync_w = {ow_byte_sync_i, ow_byte_sync_i, oh_byte_sync_i, oh_byte_sync_i};

	// 0: overhead, 1: alarm, 2: orderwire 1, 3: orderwire 2
	generate
		for (genvar i = 0; i < NSER; i++) begin : g_ser
			potx_ser_rx u_ser (
				.clk_i(clk_i),
				.rst_n_i(rst_n_i),
				.bit_i(ser_pin_w[i]),
				.strobe_i(ser_strobe_w[i]),
				.sync_i(ser_sync_w[i]),
				.byte_o(ser_byte_w[i])
			);
		end
	endgenerate

	// insert select is delayed two cycles, as much as the two-stage synchroniser on the serial pins
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ins1_ff <= 1'b0;
			ins_ff <= 1'b0;
		end else begin
			ins1_ff <= path_oh_insert_select_i;
			ins_ff <= ins1_ff;
		end
	end

	potx_rdi_gen u_rdi (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.frame_start_i(frame_start_i),
		.dfct_i(dfct_i),
		.cfg_i(cfg),
		.code_o(rdi_code_o)
	);

	// source choice shared by the c2, g1, h4, f2, f3, z4 and z5 bytes
	function automatic logic [7:0] pick(input potx_pkg::potx_src_type s,
		input logic [7:0] reg_v, input logic [7:0] int_v, input logic [7:0] ow_v);
		logic [7:0] r;
		r = potx_pkg::OH_DEFAULT;
		if (ins_ff) begin
			r = ser_byte_w[0];
		end else begin
			unique case (s)
				potx_pkg::SRC_SERIAL: r = ser_byte_w[0];
				potx_pkg::SRC_ALARM: r = ser_byte_w[1];
				potx_pkg::SRC_PASS: r = dn_data_i;
				potx_pkg::SRC_REG: r = reg_v;
				potx_pkg::SRC_INTERNAL: r = int_v;
				potx_pkg::SRC_OW: r = ow_v;
				potx_pkg::SRC_DEFAULT: r = potx_pkg::OH_DEFAULT;
				default: r = potx_pkg::OH_DEFAULT;
			endcase
		end
		return r;
	endfunction

	// rei carries the far receiver's b3 error count
	assign rei_int_w = cfg.rei_en ? dfct_i.b3_err : 4'h0;
	assign rdi_int_w = {4'h0, rdi_code_o, 1'b0};

	// a process: pick also reads insert select, serial bytes and downstream data
	always_comb begin
		rei_byte_w = pick(cfg.rei_src, potx_pkg::OH_DEFAULT, {rei_int_w, 4'h0},
			potx_pkg::OH_DEFAULT);
		rdi_byte_w = pick(cfg.rdi_src, {4'h0, tx_path_defect_reg_i}, rdi_int_w,
			potx_pkg::OH_DEFAULT);
	end

	// pointer test commands wait here; a new command wins over the clear
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pend_ff <= 3'h0;
		end else begin
			pend_ff <= (frame_start_i && move_ff == potx_pkg::MV_NONE
				&& gap_ff >= potx_pkg::PTR_MOVE_GAP) ? {ptr_new_data_flag_i, ptr_dec_i, ptr_inc_i}
				: pend_ff | {ptr_new_data_flag_i, ptr_dec_i, ptr_inc_i};
		end
	end

	// frames since the last movement began
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gap_ff <= potx_pkg::PTR_MOVE_GAP;
		end else if (frame_start_i) begin
			if (move_ff == potx_pkg::MV_NONE && gap_ff >= potx_pkg::PTR_MOVE_GAP
				&& pend_ff != 3'h0) begin
				gap_ff <= 3'h0;
			end else if (gap_ff < potx_pkg::PTR_MOVE_GAP) begin
				gap_ff <= gap_ff + 3'h1;
			end
		end
	end

	// one movement frame, applied at the next frame start
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			move_ff <= potx_pkg::MV_NONE;
		end else if (frame_start_i) begin
			if (move_ff != potx_pkg::MV_NONE) begin
				move_ff <= potx_pkg::MV_NONE;
			end else if (gap_ff >= potx_pkg::PTR_MOVE_GAP) begin
				if (pend_ff[2]) begin
					move_ff <= potx_pkg::MV_NDF;
				end else if (pend_ff[0]) begin
					move_ff <= potx_pkg::MV_INC;
				end else if (pend_ff[1]) begin
					move_ff <= potx_pkg::MV_DEC;
				end
			end
		end
	end

	// any 10-bit value is sent as is; movements wrap only within 0..782
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cur_ff <= 10'h000;
			prog_ff <= 10'h000;
		end else if (frame_start_i) begin
			prog_ff <= tx_pointer_setting_i;
			unique case (move_ff)
				potx_pkg::MV_INC:
					cur_ff <= (cur_ff == potx_pkg::PTR_MAX) ? 10'h000 : cur_ff + 10'h001;
				potx_pkg::MV_DEC:
					cur_ff <= (cur_ff == 10'h000) ? potx_pkg::PTR_MAX : cur_ff - 10'h001;
				potx_pkg::MV_NDF:
					cur_ff <= tx_pointer_setting_i;
				potx_pkg::MV_NONE:
					if (tx_pointer_setting_i != prog_ff) begin
						cur_ff <= tx_pointer_setting_i;
					end
			endcase
		end
	end

	assign tx_current_pointer_o = cur_ff;

	always_comb begin
		unique case (move_ff)
			potx_pkg::MV_INC: ptr_tx_w = cur_ff ^ potx_pkg::PTR_I_MASK;
			potx_pkg::MV_DEC: ptr_tx_w = cur_ff ^ potx_pkg::PTR_D_MASK;
			potx_pkg::MV_NDF: ptr_tx_w = tx_pointer_setting_i;
			potx_pkg::MV_NONE: ptr_tx_w = cur_ff;
		endcase
	end

	always_comb begin
		nxt_out = '0;
		nxt_out.data = dn_data_i;
		unique case (slot_i)
			potx_pkg::SL_C2:
				nxt_out.data = cfg.unequipped ? potx_pkg::OH_DEFAULT
					: pick(cfg.c2_src, tx_signal_label_reg_i, potx_pkg::OH_DEFAULT,
					potx_pkg::OH_DEFAULT);
			potx_pkg::SL_G1:
				nxt_out.data = {rei_byte_w[7:4], rdi_byte_w[3:0]};
			potx_pkg::SL_H4:
				nxt_out.data = pick(cfg.h4_src, potx_pkg::OH_DEFAULT, potx_pkg::OH_DEFAULT,
					potx_pkg::OH_DEFAULT);
			potx_pkg::SL_F2:
				nxt_out.data = pick(cfg.f2_src, potx_pkg::OH_DEFAULT, potx_pkg::OH_DEFAULT,
					ser_byte_w[2]);
			potx_pkg::SL_F3:
				nxt_out.data = pick(cfg.f3_src, potx_pkg::OH_DEFAULT, potx_pkg::OH_DEFAULT,
					ser_byte_w[3]);
			potx_pkg::SL_Z4:
				nxt_out.data = pick(cfg.z4_src, potx_pkg::OH_DEFAULT, potx_pkg::OH_DEFAULT,
					potx_pkg::OH_DEFAULT);
			potx_pkg::SL_Z5:
				nxt_out.data = pick(cfg.z5_src, potx_pkg::OH_DEFAULT, potx_pkg::OH_DEFAULT,
					potx_pkg::OH_DEFAULT);
			potx_pkg::SL_H1_PTR:
				nxt_out.data = {(move_ff == potx_pkg::MV_NDF) ? potx_pkg::NDF_SET
					: potx_pkg::NDF_NORMAL, tx_pointer_size_i, ptr_tx_w[9:8]};
			potx_pkg::SL_H2_PTR:
				nxt_out.data = ptr_tx_w[7:0];
			potx_pkg::SL_H1_CONC:
				nxt_out.data = {potx_pkg::NDF_SET, tx_pointer_size_i, potx_pkg::CONC_H1_LOW}
					^ {8{cfg.conc_inv}};
			potx_pkg::SL_H2_CONC:
				nxt_out.data = potx_pkg::CONC_H2;
			potx_pkg::SL_H3: begin
				// negative justification carries a payload byte in h3
				nxt_out.just_neg = (move_ff == potx_pkg::MV_DEC);
				nxt_out.data = nxt_out.just_neg ? dn_data_i : potx_pkg::OH_DEFAULT;
			end
			potx_pkg::SL_PJO: begin
				nxt_out.just_pos = (move_ff == potx_pkg::MV_INC);
				nxt_out.data = nxt_out.just_pos ? potx_pkg::OH_DEFAULT : dn_data_i;
			end
			potx_pkg::SL_STUFF:
				if (cfg.sts1_mode && cfg.stuff_cols) begin
					nxt_out.data = potx_pkg::OH_DEFAULT;
					nxt_out.bip_excl = 1'b1;
				end
			potx_pkg::SL_PAYLOAD, potx_pkg::SL_OTHER_POH:
				nxt_out.data = dn_data_i;
		endcase
		if (cfg.force_ais) begin
			nxt_out.data = potx_pkg::AIS_BYTE;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_o <= '0;
		end else begin
			tx_o <= nxt_out;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	AST_UNEQ_C2: assert property (slot_i == potx_pkg::SL_C2 && cfg.unequipped
		&& !cfg.force_ais |=> tx_o.data == potx_pkg::OH_DEFAULT)
		else $error("unequipped label not zero");
	AST_REI_INT: assert property (slot_i == potx_pkg::SL_G1 && !ins_ff && !cfg.force_ais
		&& cfg.rei_src == potx_pkg::SRC_INTERNAL
		|=> tx_o.data[7:4] == ($past(cfg.rei_en) ? $past(dfct_i.b3_err) : 4'h0))
		else $error("internal rei wrong");
	AST_RDI_AUTO: assert property (slot_i == potx_pkg::SL_G1 && !ins_ff && !cfg.force_ais
		&& cfg.rdi_src == potx_pkg::SRC_INTERNAL
		|=> tx_o.data[3:0] == {$past(rdi_code_o), 1'b0})
		else $error("automatic rdi or spare wrong");
	AST_INSERT: assert property (slot_i == potx_pkg::SL_H4 && ins_ff && !cfg.force_ais
		|=> tx_o.data == $past(ser_byte_w[0]))
		else $error("insert select not honoured");
	AST_AIS: assert property (cfg.force_ais [*2] |-> tx_o.data == potx_pkg::AIS_BYTE)
		else $error("forced ais not all ones");
	AST_NDF: assert property (slot_i == potx_pkg::SL_H1_PTR && !cfg.force_ais
		|=> tx_o.data[7:4] == (($past(move_ff) == potx_pkg::MV_NDF) ? potx_pkg::NDF_SET
		: potx_pkg::NDF_NORMAL))
		else $error("new data flag bits wrong");
	AST_CONC: assert property (slot_i == potx_pkg::SL_H2_CONC && !cfg.force_ais
		|=> tx_o.data == potx_pkg::CONC_H2)
		else $error("concatenation h2 wrong");
	AST_STUFF: assert property (slot_i == potx_pkg::SL_STUFF && cfg.sts1_mode
		&& cfg.stuff_cols && !cfg.force_ais |=> tx_o.bip_excl && tx_o.data == 8'h00)
		else $error("stuff column not excluded");
	AST_GAP: assert property (move_ff == potx_pkg::MV_NONE ##1 move_ff != potx_pkg::MV_NONE
		|-> gap_ff == 3'h0 && $past(gap_ff) >= potx_pkg::PTR_MOVE_GAP)
		else $error("pointer movements too close");
	AST_INC: assert property (frame_start_i && move_ff == potx_pkg::MV_INC
		&& cur_ff < potx_pkg::PTR_MAX |=> cur_ff == $past(cur_ff) + 10'h001)
		else $error("increment not applied");
	AST_DEC: assert property (frame_start_i && move_ff == potx_pkg::MV_DEC
		&& cur_ff != 10'h000 |=> cur_ff == $past(cur_ff) - 10'h001)
		else $error("decrement not applied");
	AST_JUST_POS: assert property (slot_i == potx_pkg::SL_PJO && move_ff == potx_pkg::MV_INC
		&& !cfg.force_ais |=> tx_o.just_pos && tx_o.data == potx_pkg::OH_DEFAULT)
		else $error("positive justification byte wrong");
	COV_INC: cover property (move_ff == potx_pkg::MV_INC);
	COV_DEC: cover property (move_ff == potx_pkg::MV_DEC);
	COV_NDF: cover property (move_ff == potx_pkg::MV_NDF ##[1:300] move_ff == potx_pkg::MV_INC);
endmodule
`default_nettype wire

// ---- tb/potx_oh_src.sv ----
// far-end serial overhead source: one byte msb first per go pulse
// assumes the inserter synchronises strobe and bit itself
`timescale 1ns/100ps
`default_nettype none
module potx_oh_src (
	// clock and request
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [7:0] byte_i,
	// serial pins
	output logic bit_o,
	output logic strobe_o,
	output logic sync_o
);
	initial begin
		bit_o = 1'b0;
		strobe_o = 1'b0;
		sync_o = 1'b0;
		forever begin
			@(posedge go_i);
			for (int i = 7; i >= 0; i--) begin
				@(negedge clk_i);
				bit_o = byte_i[i];
				sync_o = (i == 0);
				repeat (3) @(negedge clk_i);
				strobe_o = 1'b1;
				repeat (4) @(negedge clk_i);
				strobe_o = 1'b0;
			end
			// released line must not keep the last bit
			sync_o = 1'b0;
			bit_o = ~byte_i[0];
		end
	end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the path overhead inserter
// assumes inputs change at the falling edge, outputs one cycle after the slot
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic clk_i, rst_n_i, fs, ins, inc, dec, new_data_flag, go, ob, os, oy;
	potx_pkg::potx_slot_type slot;
	logic [7:0] dn, label, sb;
	potx_pkg::potx_cfg_type cfg;
	potx_pkg::potx_defect_type dfct;
	logic [3:0] dreg;
	logic [1:0] ss;
	logic [9:0] pset, cur;
	potx_pkg::potx_out_type tx;
	logic [2:0] rdi;
	int fail_count, total_checks;

	potx_oh_src far (.clk_i(clk_i), .go_i(go), .byte_i(sb), .bit_o(ob), .strobe_o(os),
		.sync_o(oy));
	potx_inserter dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .frame_start_i(fs), .slot_i(slot),
		.dn_data_i(dn), .path_oh_serial_in_i(ob), .path_alarm_serial_in_i(~ob),
		.oh_bit_strobe_i(os), .oh_byte_sync_i(oy), .path_oh_insert_select_i(ins),
		.path_orderwire1_in_i(ob), .path_orderwire2_in_i(~ob), .ow_bit_strobe_i(os),
		.ow_byte_sync_i(oy), .tx_path_source_cfg_i(cfg), .tx_signal_label_reg_i(label),
		.tx_path_defect_reg_i(dreg), .tx_pointer_size_i(ss), .tx_pointer_setting_i(pset),
		.ptr_inc_i(inc), .ptr_dec_i(dec), .ptr_new_data_flag_i(new_data_flag), .dfct_i(dfct),
		.tx_o(tx), .tx_current_pointer_o(cur), .rdi_code_o(rdi));

	task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic put(input potx_pkg::potx_slot_type s, input logic [7:0] d,
		input logic [7:0] e);
		slot = s;
		dn = d;
		@(negedge clk_i);
		chk(s.name(), {2'h0, e}, {2'h0, tx.data});
	endtask

	task automatic frame();
		fs = 1'b1;
		@(negedge clk_i);
		fs = 1'b0;
		@(negedge clk_i);
	endtask

	task automatic rdi_is(input logic [2:0] e);
		repeat (2) frame();
		chk("rdi_code", {7'h0, e}, {7'h0, rdi});
	endtask

	task automatic src5(input potx_pkg::potx_src_type s);
		cfg.h4_src = s;
		cfg.f2_src = s;
		cfg.f3_src = s;
		cfg.z4_src = s;
		cfg.z5_src = s;
	endtask

	task automatic t_label();
		cfg.c2_src = potx_pkg::SRC_REG;
		label = 8'h5a;
		put(potx_pkg::SL_C2, 8'h11, 8'h5a);
		cfg.c2_src = potx_pkg::SRC_PASS;
		put(potx_pkg::SL_C2, 8'h11, 8'h11);
		cfg.unequipped = 1'b1;
		put(potx_pkg::SL_C2, 8'h11, 8'h00);
		cfg.unequipped = 1'b0;
	endtask

	task automatic t_unused();
		potx_pkg::potx_slot_type sl[5] = '{potx_pkg::SL_H4, potx_pkg::SL_F2,
			potx_pkg::SL_F3, potx_pkg::SL_Z4, potx_pkg::SL_Z5};
		src5(potx_pkg::SRC_PASS);
		foreach (sl[i]) put(sl[i], 8'h30 + 8'(i), 8'h30 + 8'(i));
		src5(potx_pkg::SRC_DEFAULT);
		foreach (sl[i]) put(sl[i], 8'h30, 8'h00);
	endtask

	task automatic t_serial();
		sb = 8'hc3;
		go = 1'b1;
		@(negedge clk_i);
		go = 1'b0;
		repeat (70) @(negedge clk_i);
		ins = 1'b1;
		repeat (3) @(negedge clk_i);
		put(potx_pkg::SL_H4, 8'h11, 8'hc3);
		ins = 1'b0;
		repeat (3) @(negedge clk_i);
		src5(potx_pkg::SRC_SERIAL);
		put(potx_pkg::SL_F3, 8'h11, 8'hc3);
		cfg.f2_src = potx_pkg::SRC_OW;
		cfg.f3_src = potx_pkg::SRC_OW;
		put(potx_pkg::SL_F2, 8'h11, 8'hc3);
		put(potx_pkg::SL_F3, 8'h11, 8'h3c);
		cfg.rei_src = potx_pkg::SRC_ALARM;
		cfg.rdi_src = potx_pkg::SRC_ALARM;
		put(potx_pkg::SL_G1, 8'h11, 8'h3c);
		src5(potx_pkg::SRC_DEFAULT);
	endtask

	task automatic t_g1();
		cfg.rei_src = potx_pkg::SRC_INTERNAL;
		cfg.rei_en = 1'b1;
		dfct.b3_err = 4'h3;
		cfg.rdi_src = potx_pkg::SRC_REG;
		dreg = 4'h9;
		put(potx_pkg::SL_G1, 8'h00, 8'h39);
		cfg.rei_en = 1'b0;
		put(potx_pkg::SL_G1, 8'h00, 8'h09);
		cfg.rei_src = potx_pkg::SRC_PASS;
		cfg.rdi_src = potx_pkg::SRC_PASS;
		put(potx_pkg::SL_G1, 8'ha6, 8'ha6);
	endtask

	task automatic t_rdi();
		cfg.rei_src = potx_pkg::SRC_DEFAULT;
		cfg.rdi_src = potx_pkg::SRC_INTERNAL;
		cfg.rdi_hold_sel = 2'h3;
		cfg.rdi_enh = 1'b1;
		cfg.tim_en = 1'b1;
		cfg.slm_en = 1'b1;
		cfg.slm_payload = 1'b1;
		cfg.uneq_en = 1'b1;
		dfct.aisp = 1'b1;
		dfct.tim = 1'b1;
		rdi_is(3'h5);
		put(potx_pkg::SL_G1, 8'hff, 8'h0a);
		dfct.aisp = 1'b0;
		rdi_is(3'h6);
		dfct.tim = 1'b0;
		dfct.slm = 1'b1;
		rdi_is(3'h2);
		dfct.slm = 1'b0;
		dfct.uneq = 1'b1;
		rdi_is(3'h6);
		cfg.uneq_en = 1'b0;
		rdi_is(3'h1);
		cfg.rdi_enh = 1'b0;
		dfct.lop = 1'b1;
		rdi_is(3'h4);
		cfg.rdi_alt = 1'b1;
		rdi_is(3'h7);
		dfct.lop = 1'b0;
		rdi_is(3'h3);
		cfg.rdi_alt = 1'b0;
		cfg.rdi_hold_sel = 2'h2;
		dfct.tim = 1'b1;
		rdi_is(3'h4);
		dfct.tim = 1'b0;
		rdi_is(3'h4);
		repeat (5) frame();
		chk("rdi_code", 10'h0, {7'h0, rdi});
	endtask

	task automatic t_ptr();
		pset = 10'h123;
		ss = 2'h2;
		repeat (2) frame();
		chk("cur_ptr", 10'h123, cur);
		put(potx_pkg::SL_H1_PTR, 8'h00, 8'h69);
		put(potx_pkg::SL_H2_PTR, 8'h00, 8'h23);
		inc = 1'b1;
		@(negedge clk_i);
		inc = 1'b0;
		frame();
		put(potx_pkg::SL_H1_PTR, 8'h00, 8'h6b);
		put(potx_pkg::SL_H2_PTR, 8'h00, 8'h89);
		put(potx_pkg::SL_PJO, 8'h77, 8'h00);
		chk("just_pos", 10'h1, {9'h0, tx.just_pos});
		frame();
		chk("cur_ptr", 10'h124, cur);
		dec = 1'b1;
		@(negedge clk_i);
		dec = 1'b0;
		frame();
		put(potx_pkg::SL_H2_PTR, 8'h00, 8'h24);
		pset = 10'h3ff;
		repeat (3) frame();
		chk("cur_ptr", 10'h3ff, cur);
		put(potx_pkg::SL_H3, 8'h5c, 8'h5c);
		chk("just_neg", 10'h1, {9'h0, tx.just_neg});
		put(potx_pkg::SL_H2_PTR, 8'h00, 8'haa);
		frame();
		chk("cur_ptr", 10'h3fe, cur);
		new_data_flag = 1'b1;
		@(negedge clk_i);
		new_data_flag = 1'b0;
		repeat (3) frame();
		put(potx_pkg::SL_H1_PTR, 8'h00, 8'h6b);
		frame();
		put(potx_pkg::SL_H1_PTR, 8'h00, 8'h9b);
		frame();
		chk("cur_ptr", 10'h3ff, cur);
	endtask

	task automatic t_ais();
		put(potx_pkg::SL_H2_CONC, 8'h00, 8'hff);
		put(potx_pkg::SL_H1_CONC, 8'h00, 8'h9b);
		cfg.conc_inv = 1'b1;
		put(potx_pkg::SL_H1_CONC, 8'h00, 8'h64);
		cfg.force_ais = 1'b1;
		put(potx_pkg::SL_PAYLOAD, 8'h12, 8'hff);
		cfg.force_ais = 1'b0;
		cfg.sts1_mode = 1'b1;
		cfg.stuff_cols = 1'b1;
		slot = potx_pkg::SL_STUFF;
		repeat (2) @(negedge clk_i);
		chk("bip_excl", 10'h1, {9'h0, tx.bip_excl});
		cfg.stuff_cols = 1'b0;
		put(potx_pkg::SL_STUFF, 8'h44, 8'h44);
	endtask

	task automatic end_of_test();
		$display("checks %0d failures %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// a hang anywhere counts as a mismatch
	initial begin
		repeat (20000) @(posedge clk_i);
		fail_count++;
		end_of_test();
	end

	initial begin
		{rst_n_i, fs, ins, inc, dec, new_data_flag, go, dn, label, sb, dreg, ss, pset} = '0;
		slot = potx_pkg::SL_PAYLOAD;
		cfg = '0;
		dfct = '0;
		fail_count = 0;
		total_checks = 0;
		repeat (4) @(negedge clk_i);
		rst_n_i = 1'b1;
		@(negedge clk_i);
		t_label();
		t_unused();
		t_serial();
		t_g1();
		t_rdi();
		t_ptr();
		t_ais();
		end_of_test();
	end
endmodule
`default_nettype wire
